// ### rtl/pcc_top.sv
/*
 Clock conditioning port: reference select, loop core model with lock,
 three global multiplexers with dividers and delay taps.
 Assumes every input is synchronous to I_CLK_SYS; clocks are modelled
 as sampled levels, derived clocks as registered levels.
*/
// What this block does
// - Takes reference and feedback clocks; drives five clocks and lock.
// - Reference feeds the loop core and sources the primary output.
// - In bypass (select 001) a sync reset clears path A final divider.
// - Sync reset acts on its rising edge only, not its level.
// - With loop core in use, sync reset is ignored; generated internally.
// - Half step works only in bypass with the RC oscillator as reference.
// - Half step divides by 1.5 up to 14.5 in half steps.
// - External feedback replaces internal feedback at the phase detector.
// - Sleep low powers the loop down; high allows normal operation.
// - While asleep every clock output stays low.
// - Primary output goes to its global network.
// - Both secondary outputs go to their global networks.
// - Two core outputs go to local routing.
// - Lock rises only once steady lock between reference and feedback.
// - Reference selectable: global pins, I/O pins, core, RC or crystal.
// - Each global output comes from its own global multiplexer.
// - Each multiplexer holds source routing, output select and delays.
// - Outputs enable as A, then B group, then C group.
`timescale 1ns/1ps
`include "pcc_regs.svh"
module pcc_top (
	input  wire logic                  I_CLK_SYS,
	input  wire logic                  I_RESET_N,
	input  wire logic [`PCC_SEL_W-1:0] I_REF_SRC_SEL,
	input  wire logic                  I_REF_GLOBAL_PIN,
	input  wire logic                  I_REF_IO_PIN,
	input  wire logic                  I_REF_CORE,
	input  wire logic                  I_REF_RC_OSC,
	input  wire logic                  I_REF_XTAL_OSC,
	input  wire logic                  I_EXT_FEEDBACK_IN,
	input  wire logic                  I_USE_EXT_FB,
	input  wire logic                  I_PLL_SLEEP_N,
	input  wire logic [`PCC_SEL_W-1:0] I_OUT_A_SOURCE_SELECT,
	input  wire logic                  I_OUT_DIV_A_SYNC_RESET,
	input  wire logic                  I_OUT_DIV_A_HALF_STEP,
	input  wire logic [`PCC_DIV_W-1:0] I_DIV_A,
	input  wire logic [`PCC_DIV_W-1:0] I_DIV_B,
	input  wire logic [`PCC_DIV_W-1:0] I_DIV_C,
	input  wire logic [`PCC_DLY_W-1:0] I_DLY_A,
	input  wire logic [`PCC_DLY_W-1:0] I_DLY_B,
	input  wire logic [`PCC_DLY_W-1:0] I_DLY_C,
	input  wire logic                  I_EN_SEC1,
	input  wire logic                  I_EN_CORE1,
	input  wire logic                  I_EN_SEC2,
	input  wire logic                  I_EN_CORE2,
	output logic                       O_GLOBAL_OUT_PRIMARY,
	output logic                       O_GLOBAL_OUT_SEC1,
	output logic                       O_GLOBAL_OUT_SEC2,
	output logic                       O_CORE_OUT_1,
	output logic                       O_CORE_OUT_2,
	output logic                       O_LOCK,
	output logic                       O_GROUP_BAD
);
	localparam int PdWin = `PCC_PD_WIN_NS / `PCC_CLK_NS;

	logic                    ref_clk_in;
	logic                    ref_q;
	logic                    ref_p;
	logic                    fb_q;
	logic                    fb_p;
	logic                    srst_p;
	logic                    ref_rise;
	logic                    ref_fall;
	logic                    ext_rise;
	logic                    srst_rise;
	logic                    bypass;
	logic                    ref_is_rc;
	logic [`PCC_PER_W-1:0]   per_cnt_q;
	logic [`PCC_PER_W-1:0]   per_q;
	logic [`PCC_PER_W-1:0]   per_p;
	logic [`PCC_PER_W-1:0]   per_diff;
	logic [`PCC_PER_W-1:0]   half_per;
	logic                    stable;
	logic                    stall;
	logic                    run;
	logic                    realign;
	logic [`PCC_PER_W-1:0]   vco_cnt_q;
	logic                    vco_lvl_q;
	logic                    vco_edge;
	logic                    vco_tick_q;
	logic                    vco_rise_q;
	logic                    fb_rise;
	logic                    ph_ok_q;
	pcc_pkg::pcc_lst_t       st_q;
	pcc_pkg::pcc_lst_t       st_d;
	logic [`PCC_LOCK_W-1:0]  lk_cnt_q;
	logic [`PCC_LOCK_W-1:0]  lk_cnt_d;
	logic                    lock_q;
	logic                    lock_rise_q;
	logic                    grp1;
	logic                    gla_q;
	logic                    glb_q;
	logic                    glc_q;
	logic                    yb_q;
	logic                    yc_q;
	logic                    bad_q;

	pcc_mux_if a_if ();
	pcc_mux_if b_if ();
	pcc_mux_if c_if ();

	// Reference source multiplexer
	always_comb
	begin
		case (I_REF_SRC_SEL)
			`PCC_REF_GPIN: ref_clk_in = I_REF_GLOBAL_PIN;
			`PCC_REF_IO:   ref_clk_in = I_REF_IO_PIN;
			`PCC_REF_CORE: ref_clk_in = I_REF_CORE;
			`PCC_REF_RC:   ref_clk_in = I_REF_RC_OSC;
			`PCC_REF_XTAL: ref_clk_in = I_REF_XTAL_OSC;
			default:       ref_clk_in = 1'b0;
		endcase
	end

	// Sampled copies for edge detection
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ref_q  <= 1'b0;
			ref_p  <= 1'b0;
			fb_q   <= 1'b0;
			fb_p   <= 1'b0;
			srst_p <= 1'b0;
		end
		else
		begin
			ref_q  <= ref_clk_in;
			ref_p  <= ref_q;
			fb_q   <= I_EXT_FEEDBACK_IN;
			fb_p   <= fb_q;
			srst_p <= I_OUT_DIV_A_SYNC_RESET;
		end
	end

	// Edge events and path A mode decode
	always_comb
	begin
		ref_rise  = ref_q && !ref_p;
		ref_fall  = !ref_q && ref_p;
		ext_rise  = fb_q && !fb_p;
		bypass    = I_OUT_A_SOURCE_SELECT == `PCC_SEL_BYPASS;
		ref_is_rc = I_REF_SRC_SEL == `PCC_REF_RC;
		// Relies on the driver having held it low beforehand
		srst_rise = bypass && I_OUT_DIV_A_SYNC_RESET && !srst_p;
	end

	// Reference period measurement, cleared while asleep
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			per_cnt_q <= '0;
			per_q     <= '0;
			per_p     <= '0;
		end
		else if (!I_PLL_SLEEP_N)
		begin
			per_cnt_q <= '0;
			per_q     <= '0;
			per_p     <= '0;
		end
		else if (ref_rise)
		begin
			per_cnt_q <= `PCC_PER_W'(1);
			per_q     <= per_cnt_q;
			per_p     <= per_q;
		end
		else if (per_cnt_q != `PCC_PER_MAX)
			per_cnt_q <= per_cnt_q + 1'b1;
	end

	// Period stability and loop run condition
	always_comb
	begin
		per_diff = (per_q > per_p) ? per_q - per_p : per_p - per_q;
		stable   = per_diff <= `PCC_PER_TOL && per_q != '0 && per_p != '0;
		stall    = per_cnt_q == `PCC_PER_MAX;
		half_per = {1'b0, per_q[`PCC_PER_W-1:1]};
		if (half_per == '0)
			half_per = `PCC_PER_W'(1);
		run      = st_q != pcc_pkg::ST_SLEEP && per_q != '0;
		realign  = run && ref_rise;
		vco_edge = run && (realign || vco_cnt_q >= half_per - 1'b1);
	end

	// Oscillator model: toggles every half measured period
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			vco_cnt_q  <= '0;
			vco_lvl_q  <= 1'b0;
			vco_tick_q <= 1'b0;
			vco_rise_q <= 1'b0;
		end
		else
		begin
			vco_tick_q <= vco_edge;
			vco_rise_q <= vco_edge && (realign || !vco_lvl_q);
			if (!run || vco_edge)
				vco_cnt_q <= '0;
			else
				vco_cnt_q <= vco_cnt_q + 1'b1;
			if (!run)
				vco_lvl_q <= 1'b0;
			else if (realign)
				vco_lvl_q <= 1'b1;
			else if (vco_edge)
				vco_lvl_q <= !vco_lvl_q;
		end
	end

	// Phase detector input: external edge replaces internal one
	assign fb_rise = I_USE_EXT_FB ? ext_rise : vco_rise_q;

	// Feedback close behind the reference edge marks phase agreement
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			ph_ok_q <= 1'b0;
		else if (!I_PLL_SLEEP_N)
			ph_ok_q <= 1'b0;
		else if (ref_rise)
			ph_ok_q <= fb_rise;
		else if (fb_rise && per_cnt_q <= `PCC_PER_W'(PdWin))
			ph_ok_q <= 1'b1;
	end

	// Lock state: counts agreeing reference periods
	always_comb
	begin
		st_d     = st_q;
		lk_cnt_d = lk_cnt_q;
		case (st_q)
			pcc_pkg::ST_SLEEP:
			begin
				st_d     = pcc_pkg::ST_ACQ;
				lk_cnt_d = '0;
			end
			pcc_pkg::ST_ACQ:
			begin
				if (ref_rise && !(stable && ph_ok_q))
					lk_cnt_d = '0;
				else if (ref_rise && lk_cnt_q == `PCC_LOCK_CNT - 1'b1)
					st_d = pcc_pkg::ST_LOCK;
				else if (ref_rise)
					lk_cnt_d = lk_cnt_q + 1'b1;
			end
			pcc_pkg::ST_LOCK:
			begin
				if (stall || (ref_rise && !(stable && ph_ok_q)))
				begin
					st_d     = pcc_pkg::ST_ACQ;
					lk_cnt_d = '0;
				end
			end
			default:
			begin
				st_d     = pcc_pkg::ST_SLEEP;
				lk_cnt_d = '0;
			end
		endcase
		if (!I_PLL_SLEEP_N)
		begin
			st_d     = pcc_pkg::ST_SLEEP;
			lk_cnt_d = '0;
		end
	end

	// Lock state registers and lock outputs
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			st_q        <= pcc_pkg::ST_SLEEP;
			lk_cnt_q    <= '0;
			lock_q      <= 1'b0;
			lock_rise_q <= 1'b0;
		end
		else
		begin
			st_q        <= st_d;
			lk_cnt_q    <= lk_cnt_d;
			lock_q      <= st_d == pcc_pkg::ST_LOCK;
			lock_rise_q <= st_d == pcc_pkg::ST_LOCK
				&& st_q != pcc_pkg::ST_LOCK;
		end
	end

	// Path A routing; internal sync pulse replaces the pin in loop mode
	always_comb
	begin
		a_if.src_edge = bypass ? (ref_rise || ref_fall) : vco_tick_q;
		a_if.sync_rst = bypass ? srst_rise : lock_rise_q;
		a_if.half     = bypass && ref_is_rc && I_OUT_DIV_A_HALF_STEP;
		a_if.en       = I_PLL_SLEEP_N;
		a_if.div_n    = I_DIV_A;
		a_if.dly      = I_DLY_A;
	end

	// Paths B and C run from the loop; C needs the B group enabled
	always_comb
	begin
		grp1          = I_EN_SEC1 || I_EN_CORE1;
		b_if.src_edge = vco_tick_q;
		b_if.sync_rst = lock_rise_q;
		b_if.half     = 1'b0;
		b_if.en       = I_PLL_SLEEP_N && grp1;
		b_if.div_n    = I_DIV_B;
		b_if.dly      = I_DLY_B;
		c_if.src_edge = vco_tick_q;
		c_if.sync_rst = lock_rise_q;
		c_if.half     = 1'b0;
		c_if.en       = I_PLL_SLEEP_N && grp1
			&& (I_EN_SEC2 || I_EN_CORE2);
		c_if.div_n    = I_DIV_C;
		c_if.dly      = I_DLY_C;
	end

	// One global multiplexer per global output
	pcc_glmux u_mux_a (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RESET_N),
		.m_if    (a_if)
	);

	pcc_glmux u_mux_b (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RESET_N),
		.m_if    (b_if)
	);

	pcc_glmux u_mux_c (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RESET_N),
		.m_if    (c_if)
	);

	// Output registers; the five clock outputs are forced low while asleep, group error is not
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			gla_q <= 1'b0;
			glb_q <= 1'b0;
			glc_q <= 1'b0;
			yb_q  <= 1'b0;
			yc_q  <= 1'b0;
			bad_q <= 1'b0;
		end
		else
		begin
			gla_q <= I_PLL_SLEEP_N && a_if.gl_out;
			glb_q <= b_if.en && I_EN_SEC1 && b_if.gl_out;
			glc_q <= c_if.en && I_EN_SEC2 && c_if.gl_out;
			yb_q  <= b_if.en && I_EN_CORE1 && b_if.core_out;
			yc_q  <= c_if.en && I_EN_CORE2 && c_if.core_out;
			bad_q <= (I_EN_SEC2 || I_EN_CORE2) && !grp1;
		end
	end

	assign O_GLOBAL_OUT_PRIMARY = gla_q;
	assign O_GLOBAL_OUT_SEC1    = glb_q;
	assign O_GLOBAL_OUT_SEC2    = glc_q;
	assign O_CORE_OUT_1         = yb_q;
	assign O_CORE_OUT_2         = yc_q;
	assign O_LOCK               = lock_q;
	assign O_GROUP_BAD          = bad_q;

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RESET_N);

	sequence s_wake;
		!I_PLL_SLEEP_N ##1 I_PLL_SLEEP_N;
	endsequence

	property p_sleep_out;
		!I_PLL_SLEEP_N |=> !O_GLOBAL_OUT_PRIMARY && !O_GLOBAL_OUT_SEC1
			&& !O_GLOBAL_OUT_SEC2 && !O_CORE_OUT_1 && !O_CORE_OUT_2;
	endproperty
	a_sleep_out: assert property (p_sleep_out)
		else $error("Clock output high while asleep");

	property p_sleep_lock;
		!I_PLL_SLEEP_N |=> !O_LOCK;
	endproperty
	a_sleep_lock: assert property (p_sleep_lock)
		else $error("Lock high while asleep");

	property p_relock;
		s_wake |-> !O_LOCK [*8];
	endproperty
	a_relock: assert property (p_relock)
		else $error("Lock rose too soon after wake");

	property p_lock_cause;
		$rose(O_LOCK) |-> $past(ref_rise) && $past(stable)
			&& $past(ph_ok_q);
	endproperty
	a_lock_cause: assert property (p_lock_cause)
		else $error("Lock rose without steady agreement");

	property p_loop_sync;
		!bypass |-> a_if.sync_rst == lock_rise_q;
	endproperty
	a_loop_sync: assert property (p_loop_sync)
		else $error("Sync pin reached divider in loop mode");

	property p_level_ignored;
		bypass && I_OUT_DIV_A_SYNC_RESET && srst_p |-> !a_if.sync_rst;
	endproperty
	a_level_ignored: assert property (p_level_ignored)
		else $error("Sync reset acted on a level");

	property p_half_gate;
		!(bypass && ref_is_rc) |-> !a_if.half;
	endproperty
	a_half_gate: assert property (p_half_gate)
		else $error("Half step active outside its mode");

	property p_group;
		!(I_EN_SEC1 || I_EN_CORE1) |=> !O_GLOBAL_OUT_SEC2 && !O_CORE_OUT_2
			&& O_GROUP_BAD == $past(I_EN_SEC2 || I_EN_CORE2);
	endproperty
	a_group: assert property (p_group)
		else $error("Path C ran without path B group");

	property p_ext_fb;
		I_USE_EXT_FB |-> fb_rise == (fb_q && !fb_p);
	endproperty
	a_ext_fb: assert property (p_ext_fb)
		else $error("External feedback not at phase detector");
endmodule

// ### inc/pcc_regs.svh
/*
 Constants of the clock conditioning port: widths, encodings, timing.
 Assumes inclusion by every file of the block before use.
*/
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// Source select of output path A
`define PCC_SEL_W      3
`define PCC_SEL_BYPASS 3'h1

// Reference source encodings
`define PCC_REF_GPIN   3'h0
`define PCC_REF_IO     3'h1
`define PCC_REF_CORE   3'h2
`define PCC_REF_RC     3'h3
`define PCC_REF_XTAL   3'h4

// Period measurement
`define PCC_PER_W      16
`define PCC_PER_MAX    16'hffff
`define PCC_PER_TOL    16'h0002

// Output dividers; half step covers 1.5 up to 14.5
`define PCC_DIV_W      5
`define PCC_CNT_W      6
`define PCC_HALF_MAX   5'h0e

// Delay taps
`define PCC_DLY_W      3
`define PCC_DLY_LEN    8
`define PCC_DLY_TOP    4'h7
`define PCC_CORE_XTRA  4'h2

// Lock detection
`define PCC_LOCK_W     4
`define PCC_LOCK_CNT   4'h8
`define PCC_PD_WIN_NS  20
`define PCC_CLK_NS     5

`endif

// ### inc/pcc_pkg.sv
/*
 Types of the clock conditioning port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pcc_pkg;

	// Loop state, one-hot
	typedef enum logic [2:0]
	{
		ST_SLEEP = 3'h1,
		ST_ACQ   = 3'h2,
		ST_LOCK  = 3'h4
	} pcc_lst_t;

endpackage

// ### inc/pcc_mux_if.sv
/*
 Link between the loop control and one global multiplexer.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
`include "pcc_regs.svh"
interface pcc_mux_if;
	logic                  src_edge;
	logic                  sync_rst;
	logic                  half;
	logic                  en;
	logic [`PCC_DIV_W-1:0] div_n;
	logic [`PCC_DLY_W-1:0] dly;
	logic                  gl_out;
	logic                  core_out;

	modport ctl (output src_edge, sync_rst, half, en, div_n, dly,
		input gl_out, core_out);
	modport mux (input src_edge, sync_rst, half, en, div_n, dly,
		output gl_out, core_out);
endinterface

// ### rtl/pcc_glmux.sv
/*
 Global multiplexer: divider counting source edges, plus delay taps.
 Assumes source edges arrive as one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`include "pcc_regs.svh"
module pcc_glmux (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	pcc_mux_if.mux    m_if
);
	logic [`PCC_DIV_W-1:0]   n;
	logic [`PCC_CNT_W-1:0]   m;
	logic [`PCC_CNT_W-1:0]   cnt_q;
	logic                    div_q;
	logic [`PCC_DLY_LEN-1:0] dl_q;
	logic [`PCC_DLY_W:0]     ctap;

	// Ratio in source half periods: 2n, or 2n+1 with half step
	always_comb
	begin
		n = (m_if.div_n == '0) ? `PCC_DIV_W'(1) : m_if.div_n;
		if (m_if.half && n > `PCC_HALF_MAX)
			n = `PCC_HALF_MAX;
		m = {n, m_if.half};
	end

	// Edge counter, cleared by the sync reset pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_q <= '0;
		else if (m_if.sync_rst || !m_if.en)
			cnt_q <= '0;
		else if (m_if.src_edge)
			cnt_q <= (cnt_q >= m - 1'b1) ? '0 : cnt_q + 1'b1;
	end

	// Divided clock and its delay line
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_q <= 1'b0;
			dl_q  <= '0;
		end
		else
		begin
			div_q <= m_if.en && (cnt_q < {1'b0, n});
			dl_q  <= {dl_q[`PCC_DLY_LEN-2:0], div_q};
		end
	end

	// Core tap sits two taps further down the line than the global tap, capped at tap 7
	always_comb
	begin
		ctap = {1'b0, m_if.dly} + `PCC_CORE_XTRA;
		if (ctap > `PCC_DLY_TOP)
			ctap = `PCC_DLY_TOP;
		m_if.gl_out   = dl_q[m_if.dly];
		m_if.core_out = dl_q[ctap[`PCC_DLY_W-1:0]];
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_sync_clr;
		m_if.sync_rst |=> cnt_q == '0;
	endproperty
	a_sync_clr: assert property (p_sync_clr)
		else $error("Divider not cleared by sync reset");

	property p_half_ratio;
		m_if.half |-> m[0] && n <= `PCC_HALF_MAX && n != '0;
	endproperty
	a_half_ratio: assert property (p_half_ratio)
		else $error("Half step ratio out of range");

	property p_wrap;
		m_if.en && !m_if.sync_rst && m_if.src_edge && cnt_q == m - 1'b1
			|=> cnt_q == '0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Divider did not wrap at its ratio");
endmodule

// ### verif/pcc_far_model.sv
/*
 Far-side model: a reference clock source and an external feedback echo.
 Assumes the bench clock; levels change at its falling edge.
*/
`timescale 1ns/1ps
module pcc_far_model (
	input  wire logic       i_clk,
	input  wire logic       i_run,
	input  wire logic       i_fb_on,
	input  wire logic [7:0] i_half,
	output logic            o_ref,
	output logic            o_fb
);
	logic [7:0] cnt_q;
	logic       run_q;
	logic       fb_on_q;
	logic [7:0] half_q;

	// Start from a known level so the first edge is a clean one
	initial
	begin
		cnt_q   = 8'h00;
		run_q   = 1'b0;
		fb_on_q = 1'b0;
		half_q  = 8'h02;
		o_ref   = 1'b0;
		o_fb    = 1'b0;
	end

	// Controls taken at the rising edge, clear of the bench's falling edge
	always @(posedge i_clk)
	begin
		run_q   <= i_run;
		fb_on_q <= i_fb_on;
		half_q  <= i_half;
	end

	// Reference toggles every i_half cycles and stands still when stopped
	always @(negedge i_clk)
	begin
		if (!run_q)
			cnt_q <= 8'h00;
		else if (cnt_q + 8'h01 >= half_q)
		begin
			cnt_q <= 8'h00;
			o_ref <= ~o_ref;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end

	// Feedback echoes the reference one cycle late, or stays low when cut
	always @(negedge i_clk)
		o_fb <= fb_on_q ? o_ref : 1'b0;
endmodule

// ### verif/tb_pll_clock_conditioning_port.sv
/*
 Self-checking bench of the clock conditioning port with a period model.
 Assumes the design files and the far-side model are compiled first.
*/
`timescale 1ns/1ps
`include "pcc_regs.svh"
module tb_pll_clock_conditioning_port;
	logic                  clk;
	logic                  rst_n;
	logic                  run;
	logic                  fb_on;
	logic                  noise;
	logic                  use_ext;
	logic                  sleep_n;
	logic                  sync_rst;
	logic                  half;
	logic                  bad;
	logic [7:0]            hp;
	logic [3:0]            en;
	logic [`PCC_SEL_W-1:0] src;
	logic [`PCC_SEL_W-1:0] asel;
	logic [`PCC_DIV_W-1:0] dv [3];
	logic [`PCC_DLY_W-1:0] dl [3];
	logic [4:0]            pin;
	logic [5:0]            o;
	logic                  far_ref;
	logic                  far_fb;
	logic [31:0]           seed;
	int                    errors;
	int                    total_checks;
	int                    n, hi, lo, k, d;

	pcc_far_model far (.i_clk(clk), .i_run(run), .i_fb_on(fb_on),
		.i_half(hp), .o_ref(far_ref), .o_fb(far_fb));

	// Two clock inputs in, five clocks and lock out
	pcc_top dut (
		.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_REF_SRC_SEL(src),
		.I_REF_GLOBAL_PIN(pin[0]), .I_REF_IO_PIN(pin[1]),
		.I_REF_CORE(pin[2]), .I_REF_RC_OSC(pin[3]),
		.I_REF_XTAL_OSC(pin[4]), .I_EXT_FEEDBACK_IN(far_fb),
		.I_USE_EXT_FB(use_ext), .I_PLL_SLEEP_N(sleep_n),
		.I_OUT_A_SOURCE_SELECT(asel), .I_OUT_DIV_A_SYNC_RESET(sync_rst),
		.I_OUT_DIV_A_HALF_STEP(half), .I_DIV_A(dv[0]), .I_DIV_B(dv[1]),
		.I_DIV_C(dv[2]), .I_DLY_A(dl[0]), .I_DLY_B(dl[1]),
		.I_DLY_C(dl[2]), .I_EN_SEC1(en[0]), .I_EN_CORE1(en[1]),
		.I_EN_SEC2(en[2]), .I_EN_CORE2(en[3]),
		.O_GLOBAL_OUT_PRIMARY(o[0]), .O_GLOBAL_OUT_SEC1(o[1]),
		.O_GLOBAL_OUT_SEC2(o[2]), .O_CORE_OUT_1(o[3]),
		.O_CORE_OUT_2(o[4]), .O_LOCK(o[5]), .O_GROUP_BAD(bad));

	// Chosen candidate carries the reference, the rest carry fast noise
	always_comb
		for (int j = 0; j < 5; j++)
			pin[j] = (32'(src) == j) ? far_ref : noise;

	// System clock, 5 ns period
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Noise toggles every cycle so a wrong source shows at once
	always @(negedge clk)
		noise <= ~noise;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Effective divide factor: zero reads as one, half step clamps at 14
	function automatic int eff_n(input int nv, input logic h);
		eff_n = (nv == 0) ? 1 : nv;
		if (h && eff_n > 14)
			eff_n = 14;
	endfunction

	task automatic step(input int c);
		repeat (c) @(negedge clk);
	endtask

	task automatic chk_int(input int got, input int exp);
		total_checks++;
		if (got != exp)
		begin
			errors++;
			$display("BAD %0t got %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t level %b expected %b", $time, got, exp);
		end
	endtask

	// Count cycles until output b shows level v, bounded
	task automatic wait_lvl(input int b, input logic v, output int c);
		c = 0;
		while (o[b] !== v && c < 1000)
		begin
			step(1);
			c++;
		end
		chk_int(int'(c < 1000), 1);
	endtask

	// High and low time of one whole period, partial period skipped
	task automatic measure(input int b, output int h, output int l);
		wait_lvl(b, 1'b0, n);
		wait_lvl(b, 1'b1, n);
		wait_lvl(b, 1'b0, h);
		wait_lvl(b, 1'b1, l);
	endtask

	task automatic hold_low(input logic [5:0] m, input int c);
		logic seen;
		seen = 1'b0;
		repeat (c)
		begin
			step(1);
			seen = seen | (|(o & m));
		end
		chk_bit(seen, 1'b0);
	endtask

	// Bypass path A: periods follow the reference edges directly
	task automatic path_a(input int s, input int nv, input logic h);
		int e;
		src = s[2:0];
		asel = `PCC_SEL_BYPASS;
		dv[0] = nv[4:0];
		half = h;
		e = eff_n(nv, h && s == 3) * int'(hp);
		// Let a ratio change pass the pipeline before timing a period
		step(8);
		measure(0, hi, lo);
		chk_int(hi, e);
		chk_int(lo, (h && s == 3) ? e + int'(hp) : e);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial
	begin
		#300000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		stop_test;
	end

	initial
	begin
		rst_n = 1'b0; run = 1'b0; fb_on = 1'b1; noise = 1'b0;
		use_ext = 1'b1; sleep_n = 1'b0; sync_rst = 1'b0; half = 1'b0;
		hp = 8'h02; en = 4'hf; src = 3'h0; asel = 3'h0;
		dv = '{5'h01, 5'h01, 5'h01};
		dl = '{3'h0, 3'h0, 3'h0};
		seed = 32'hf5fe;
		errors = 0;
		total_checks = 0;
		step(16);
		rst_n = 1'b1;
		hold_low(6'h3f, 20);
		run = 1'b1;
		step(4);
		sleep_n = 1'b1;
		// Every reference source in bypass, then an unused encoding
		for (k = 0; k < 5; k++)
			path_a(k, 1, 1'b0);
		src = 3'h5;
		step(16);
		hold_low(6'h01, 40);
		// Random factors with half step on the RC source and elsewhere
		for (k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			path_a(3, int'(seed % 5) + 1, 1'b1);
			path_a(k, int'(seed % 5) + 1, 1'b1);
		end
		path_a(3, 31, 1'b1);
		// Sync reset edge realigns path A early; a held level does not
		hp = 8'h04;
		path_a(0, 6, 1'b0);
		wait_lvl(0, 1'b0, n);
		step(2);
		sync_rst = 1'b1;
		wait_lvl(0, 1'b1, n);
		chk_int(int'(n <= 14), 1);
		measure(0, hi, lo);
		chk_int(lo, 24);
		sync_rst = 1'b0;
		// Loop mode: sleep, wake and lock with external feedback
		asel = 3'h0;
		seed = lfsr(seed);
		dv = '{5'h06, 5'(seed % 4 + 1), 5'(seed % 4 + 1)};
		d = int'(seed[6:4] % 5);
		dl = '{3'h0, 3'h0, 3'(d)};
		sleep_n = 1'b0;
		step(2);
		hold_low(6'h3f, 20);
		sleep_n = 1'b1;
		wait_lvl(5, 1'b1, n);
		chk_int(int'(n >= 9 * 2 * int'(hp)), 1);
		measure(1, hi, lo);
		chk_int(hi, int'(dv[1]) * int'(hp));
		chk_int(lo, int'(dv[1]) * int'(hp));
		wait_lvl(1, 1'b0, n);
		wait_lvl(1, 1'b1, n);
		wait_lvl(2, 1'b1, n);
		chk_int(n, d);
		wait_lvl(1, 1'b0, n);
		wait_lvl(1, 1'b1, n);
		wait_lvl(3, 1'b1, n);
		chk_int(n, 2);
		wait_lvl(2, 1'b0, n);
		wait_lvl(2, 1'b1, n);
		wait_lvl(4, 1'b1, n);
		chk_int(n, 2);
		// Sync reset is ignored while the loop drives path A
		wait_lvl(0, 1'b1, n);
		wait_lvl(0, 1'b0, n);
		step(2);
		sync_rst = 1'b1;
		wait_lvl(0, 1'b1, n);
		chk_int(n, 22);
		sync_rst = 1'b0;
		// Missing external feedback drops lock; internal feedback regains
		fb_on = 1'b0;
		wait_lvl(5, 1'b0, n);
		chk_int(int'(n <= 10 * int'(hp)), 1);
		use_ext = 1'b0;
		wait_lvl(5, 1'b1, n);
		chk_int(int'(n < 200), 1);
		// Every output enable grouping
		for (k = 0; k < 16; k++)
		begin
			en = k[3:0];
			step(12);
			chk_bit(bad, (en[2] | en[3]) & ~(en[0] | en[1]));
			if (!(en[0] | en[1]))
				hold_low(6'h1e, 30);
		end
		// Second reset in mid-run clears everything
		rst_n = 1'b0;
		step(1);
		hold_low(6'h3f, 3);
		chk_bit(bad, 1'b0);
		rst_n = 1'b1;
		hold_low(6'h20, 4);
		stop_test;
	end
endmodule
